// ==== design/mic_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and types for the motion interrupt control block
// Assumes: 25 MHz system clock, byte-wide register port
// Notes:   offsets are byte addresses of the register port
//////////////////////////////////////////////////////////////////////////////
package mic_pkg;
	// register offsets
	localparam logic [7:0] ADDR_STATUS_LOW  = 8'h2C;
	localparam logic [7:0] ADDR_STATUS_HIGH = 8'h2D;
	localparam logic [7:0] ADDR_EN_LOW      = 8'h40;
	localparam logic [7:0] ADDR_EN_HIGH     = 8'h41;
	localparam logic [7:0] ADDR_PIN_CFG     = 8'h42;
	localparam logic [7:0] ADDR_PULSE_LEN   = 8'h43;
	localparam logic [7:0] ADDR_ANGLE_CFG   = 8'h44;
	localparam logic [7:0] ADDR_BLOCK_MODE  = 8'h45;
	localparam logic [7:0] ADDR_LIMIT_LOW   = 8'h46;
	localparam logic [7:0] ADDR_LIMIT_HIGH  = 8'h47;
	localparam logic [7:0] REG_RESET        = 8'h00;
	// pin configuration fields
	localparam int CFG_POL_TWO  = 7;
	localparam int CFG_AUTO_ONE = 6;
	localparam int CFG_POL_ONE  = 5;
	localparam int CFG_CLR_ANY  = 4;
	localparam int CFG_DRV_TWO  = 2;
	localparam int CFG_DRV_ONE  = 0;
	// low enable / status bits
	localparam int EV_LOW_ACCEL  = 7;
	localparam int EV_HIGH_ACCEL = 6;
	localparam int EV_INACTIVE   = 5;
	localparam int EV_ACTIVE     = 4;
	localparam int EV_DOUBLE_TAP = 3;
	localparam int EV_SINGLE_TAP = 2;
	localparam int EV_FLAT       = 1;
	localparam int EV_ORIENT     = 0;
	// high enable / status bits
	localparam int EV_SIG_MOTION = 4;
	localparam int EV_BUFFER_FILL_THRESHOLD  = 3;
	localparam int EV_ROT_READY  = 2;
	localparam int EV_LIN_READY  = 1;
	localparam int EV_FREE_FALL  = 0;
	localparam int HIGH_EVENTS   = 5;
	// orientation configuration fields
	localparam int ANGLE_UPDOWN_OFF = 6;
	localparam int THETA_MSB        = 5;
	localparam int BLOCK_MODE_LSB   = 2;
	localparam int ORIENT_MODE_LSB  = 0;
	// two-bit encodings
	localparam logic [1:0] DRV_NONE    = 2'h0;
	localparam logic [1:0] DRV_OPEN    = 2'h2;
	localparam logic [1:0] BLK_NONE    = 2'h0;
	localparam logic [1:0] BLK_ACCEL   = 2'h1;
	localparam logic [1:0] BLK_SLOPE_L = 2'h2;
	localparam logic [1:0] BLK_SLOPE_H = 2'h3;
	localparam logic [1:0] MODE_HIGH   = 2'h1;
	localparam logic [1:0] MODE_LOW    = 2'h2;
	// slope limits as fractions of the 1.5g limit: 0.2g = 2/15, 0.4g = 4/15
	localparam int SLOPE_LOW_NUM  = 2;
	localparam int SLOPE_HIGH_NUM = 4;
	localparam int LIMIT_DEN      = 15;
	// timing
	localparam int CLOCK_HZ  = 25_000_000;
	localparam int TICK_HZ   = 512;
	localparam int STABLE_MS = 100;
	localparam int TICK_CYCLES_DEF   = CLOCK_HZ / TICK_HZ;
	localparam int STABLE_CYCLES_DEF = (CLOCK_HZ / 1000) * STABLE_MS;
	// types
	typedef struct packed {
		logic [7:0]             low;
		logic [HIGH_EVENTS-1:0] high;
	} mic_events_s;
	typedef struct packed {
		logic out;
		logic oe;
	} mic_pin_s;
	typedef enum logic [1:0] {ORIENT_SYM, ORIENT_HIGH_ASYM, ORIENT_LOW_ASYM} mic_orient_e;
	typedef enum logic {PULSE_IDLE, PULSE_ON} mic_pulse_e;
endpackage

// ==== design/mic_motion_interrupt_control.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: event latching, interrupt pin control and orientation blocking
// Assumes: events and sensor figures come from logic on i_clock
// Notes:   both pins show the same latched status; pin one may auto-clear
//          slope limits are fixed fractions of the 1.5g word, truncated
//          orientation stability is counted in system clock cycles
//////////////////////////////////////////////////////////////////////////////
// Operation
// - low enable bits gate low-g, high-g, inactivity, activity, taps, flat, orientation.
// - high enable bit 4 significant motion, bit 3 buffer_fill_threshold; bits 7..5 reserved.
// - high enable bit 2 rotation data ready, bit 1 linear data ready.
// - high enable bit 0 gates the free-fall event.
// - config bit 7 set makes pin two active low.
// - config bit 5 taken as pin one polarity, set means active low.
// - config bit 6 makes pin one a timed pulse, else held until status read.
// - config bit 4 lets any register read clear status, else status reads only.
// - config bits 3..2 pick pin two driver: none, push-pull, open drain.
// - config bits 1..0 pick pin one driver with the same encoding.
// - pin one pulse ends when a 512 Hz count reaches the length value.
// - angle config bit 6 suppresses up/down orientation events.
// - six-bit theta serves both flat detection and orientation blocking.
// - blocking mode 01 blocks on theta or acceleration above 1.5g.
// - mode 10 also blocks on slope above 0.2g.
// - mode 11 blocks on slope above 0.4g, 1.5g, theta, or unstable 100 ms.
// - orientation mode 00/11 symmetrical, 01 high-asym, 10 low-asym.
// - the 1.5g limit is a sixteen-bit value in two byte registers.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module mic_motion_interrupt_control
	import mic_pkg::*;
#(
	parameter int TICK_CYCLES   = TICK_CYCLES_DEF,
	parameter int STABLE_CYCLES = STABLE_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	// register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	// event detectors
	input  mic_events_s      i_events,
	input  wire logic        i_orient_updown,
	input  wire logic [2:0]  i_orient_value,
	input  wire logic [5:0]  i_tilt_angle,
	input  wire logic [15:0] i_accel_peak,
	input  wire logic [15:0] i_slope_peak,
	// orientation decision mode
	output mic_orient_e      o_orient_mode,
	// interrupt pins
	output logic             o_int_pin_one_out,
	output logic             o_int_pin_one_oe,
	output logic             o_int_pin_two_out,
	output logic             o_int_pin_two_oe
);
	localparam int TICK_W   = $clog2(TICK_CYCLES + 1);
	localparam int STABLE_W = $clog2(STABLE_CYCLES + 1);
	localparam logic [TICK_W-1:0]   TICK_LAST  = TICK_W'(TICK_CYCLES - 1);
	localparam logic [STABLE_W-1:0] STABLE_END = STABLE_W'(STABLE_CYCLES);

	// configuration registers
	logic [7:0]              event_enable_low;
	logic [HIGH_EVENTS-1:0]  event_enable_high;
	logic [7:0]              interrupt_pin_config;
	logic [7:0]              pin_one_pulse_length;
	logic [7:0]              orientation_angle_config;
	logic [7:0]              orientation_block_mode;
	logic [15:0]             accel_limit;
	// status and event qualification
	mic_events_s             status;
	mic_events_s             raised;
	mic_events_s             set_now;
	logic                    clear_now;
	// orientation blocking
	logic                    angle_cond;
	logic                    over_accel;
	logic                    over_slope_low;
	logic                    over_slope_high;
	logic                    block_now;
	logic [18:0]             slope_low_lim;
	logic [18:0]             slope_high_lim;
	logic [2:0]              orient_prev;
	logic [STABLE_W-1:0]     stable_count;
	logic                    stable;
	// pulse timing
	logic [TICK_W-1:0]       tick_count;
	logic                    tick;
	logic [7:0]              pulse_count;
	mic_pulse_e              pulse_state;
	// pin drive
	logic                    pending;
	logic                    active_one;
	mic_pin_s                pin_one;
	mic_pin_s                pin_two;
	logic [1:0]              block_mode;
	logic [1:0]              orient_field;

	// maps driver mode, activity and polarity to a pin drive
	function automatic mic_pin_s drive_pin(input logic [1:0] mode, input logic active, input logic pol_low);
		mic_pin_s p;
		logic     lvl;
		lvl = active ^ pol_low;
		p.out = 1'b0;
		p.oe = 1'b0;
		if (mode == DRV_OPEN) begin
			p.oe = ~lvl; // only ever pulls low
		end else if (mode != DRV_NONE) begin
			p.out = lvl;
			p.oe = 1'b1;
		end
		return p;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// register writes
	// reserved bits are dropped on the way in, so they read back zero
	// unmapped offsets, status included, are ignored
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			event_enable_low <= REG_RESET;
			event_enable_high <= HIGH_EVENTS'(REG_RESET);
			interrupt_pin_config <= REG_RESET;
			pin_one_pulse_length <= REG_RESET;
			orientation_angle_config <= REG_RESET;
			orientation_block_mode <= REG_RESET;
			accel_limit <= {REG_RESET, REG_RESET};
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				ADDR_EN_LOW:     event_enable_low <= i_reg_wdata;
				ADDR_EN_HIGH:    event_enable_high <= i_reg_wdata[HIGH_EVENTS-1:0];
				ADDR_PIN_CFG:    interrupt_pin_config <= i_reg_wdata;
				ADDR_PULSE_LEN:  pin_one_pulse_length <= i_reg_wdata;
				ADDR_ANGLE_CFG:  orientation_angle_config <= {1'b0, i_reg_wdata[6:0]};
				ADDR_BLOCK_MODE: orientation_block_mode <= {4'h0, i_reg_wdata[3:0]};
				ADDR_LIMIT_LOW:  accel_limit[7:0] <= i_reg_wdata;
				ADDR_LIMIT_HIGH: accel_limit[15:8] <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// register reads, answered on the edge after the strobe
	// reads never touch status here; the status process clears it
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_reg_rdata <= REG_RESET;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				ADDR_STATUS_LOW:  o_reg_rdata <= status.low;
				ADDR_STATUS_HIGH: o_reg_rdata <= {3'h0, status.high};
				ADDR_EN_LOW:      o_reg_rdata <= event_enable_low;
				ADDR_EN_HIGH:     o_reg_rdata <= {3'h0, event_enable_high}; // reserved read zero
				ADDR_PIN_CFG:     o_reg_rdata <= interrupt_pin_config;
				ADDR_PULSE_LEN:   o_reg_rdata <= pin_one_pulse_length;
				ADDR_ANGLE_CFG:   o_reg_rdata <= orientation_angle_config;
				ADDR_BLOCK_MODE:  o_reg_rdata <= orientation_block_mode;
				ADDR_LIMIT_LOW:   o_reg_rdata <= accel_limit[7:0];
				ADDR_LIMIT_HIGH:  o_reg_rdata <= accel_limit[15:8];
				default:          o_reg_rdata <= REG_RESET;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// orientation blocking conditions
	// slope limits scale the 1.5g word by 2/15 and 4/15, truncated
	// 19-bit products so the scaling never wraps
	assign block_mode = orientation_block_mode[BLOCK_MODE_LSB+1:BLOCK_MODE_LSB];
	assign angle_cond = i_tilt_angle < orientation_angle_config[THETA_MSB:0];
	assign over_accel = i_accel_peak > accel_limit;
	assign slope_low_lim = 19'((19'(accel_limit) * 19'(SLOPE_LOW_NUM)) / 19'(LIMIT_DEN));
	assign slope_high_lim = 19'((19'(accel_limit) * 19'(SLOPE_HIGH_NUM)) / 19'(LIMIT_DEN));
	assign over_slope_low = 19'(i_slope_peak) > slope_low_lim;
	assign over_slope_high = 19'(i_slope_peak) > slope_high_lim;
	assign stable = stable_count == STABLE_END;

	always_comb begin
		unique case (block_mode)
			BLK_NONE:    block_now = 1'b0;
			BLK_ACCEL:   block_now = angle_cond | over_accel;
			BLK_SLOPE_L: block_now = angle_cond | over_slope_low | over_accel;
			BLK_SLOPE_H: block_now = angle_cond | over_slope_high | over_accel | ~stable;
		endcase
	end

	// counts how long the orientation value has held still
	// saturates at the end count so a long hold never wraps to unstable
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			orient_prev <= 3'h0;
			stable_count <= '0;
		end else begin
			orient_prev <= i_orient_value;
			if (i_orient_value != orient_prev) begin
				stable_count <= '0;
			end else if (!stable) begin
				stable_count <= stable_count + STABLE_W'(1);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// qualified events and status latching
	// flat needs the tilt under theta; orientation may be held back
	always_comb begin
		raised = i_events;
		raised.low[EV_ORIENT] = i_events.low[EV_ORIENT] & ~block_now
			& ~(orientation_angle_config[ANGLE_UPDOWN_OFF] & i_orient_updown);
		raised.low[EV_FLAT] = i_events.low[EV_FLAT] & angle_cond;
		set_now.low = raised.low & event_enable_low;
		set_now.high = raised.high & event_enable_high;
	end

	// status reads always clear; any read clears under the policy bit
	assign clear_now = i_reg_rd & (interrupt_pin_config[CFG_CLR_ANY]
		| i_reg_addr == ADDR_STATUS_LOW | i_reg_addr == ADDR_STATUS_HIGH);

	// a set in the clearing cycle survives
	// so an event landing on the host's read is never lost
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			status <= '0;
		end else if (clear_now) begin
			status <= set_now;
		end else begin
			status <= status | set_now;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// 512 Hz tick for pulse timing
	// free running: the first tick of a pulse may come early, so a pulse
	// may fall up to one tick period short of length times the tick
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			tick_count <= '0;
			tick <= 1'b0;
		end else begin
			tick <= tick_count == TICK_LAST;
			tick_count <= (tick_count == TICK_LAST) ? '0 : tick_count + TICK_W'(1);
		end
	end

	// pin one pulse, restarted by every new latched event
	// the count is compared before it steps, so length 0 gives one cycle
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			pulse_state <= PULSE_IDLE;
			pulse_count <= 8'h00;
		end else if (set_now != '0) begin
			pulse_state <= PULSE_ON;
			pulse_count <= 8'h00;
		end else begin
			unique case (pulse_state)
				PULSE_IDLE: pulse_count <= 8'h00;
				PULSE_ON: begin
					if (pulse_count == pin_one_pulse_length) begin
						pulse_state <= PULSE_IDLE;
					end else if (tick) begin
						pulse_count <= pulse_count + 8'h01;
					end
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// pin drive
	// both pins share one pending flag; only pin one can pulse
	// open drain only ever sinks, push-pull drives both levels
	assign pending = status != '0;
	assign active_one = interrupt_pin_config[CFG_AUTO_ONE] ? pulse_state == PULSE_ON : pending;
	assign pin_one = drive_pin(interrupt_pin_config[CFG_DRV_ONE+1:CFG_DRV_ONE], active_one,
		interrupt_pin_config[CFG_POL_ONE]);
	assign pin_two = drive_pin(interrupt_pin_config[CFG_DRV_TWO+1:CFG_DRV_TWO], pending,
		interrupt_pin_config[CFG_POL_TWO]);
	assign orient_field = orientation_block_mode[ORIENT_MODE_LSB+1:ORIENT_MODE_LSB];

	// registered pin and mode outputs
	// registered so a config write never glitches the pins
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			o_int_pin_one_out <= 1'b0;
			o_int_pin_one_oe <= 1'b0;
			o_int_pin_two_out <= 1'b0;
			o_int_pin_two_oe <= 1'b0;
			o_orient_mode <= ORIENT_SYM;
		end else begin
			o_int_pin_one_out <= pin_one.out;
			o_int_pin_one_oe <= pin_one.oe;
			o_int_pin_two_out <= pin_two.out;
			o_int_pin_two_oe <= pin_two.oe;
			unique case (orient_field)
				MODE_HIGH: o_orient_mode <= ORIENT_HIGH_ASYM;
				MODE_LOW:  o_orient_mode <= ORIENT_LOW_ASYM;
				default:   o_orient_mode <= ORIENT_SYM;
			endcase
		end
	end
endmodule // mic_motion_interrupt_control

// ==== bench/mic_host_model.sv ====
////////////////////////////////
// Purpose: host side of the two interrupt lines
// Assumes: board pull-ups on both lines
// Notes:   an undriven line reads high
////////////////////////////////
`timescale 1ns/1ns
module mic_host_model (
	// device pin drivers
	input  wire logic i_one_out,
	input  wire logic i_one_oe,
	input  wire logic i_two_out,
	input  wire logic i_two_oe,
	// resolved line levels
	output logic      o_line_one,
	output logic      o_line_two
);
	// pull-up wins when nobody drives
	assign o_line_one = i_one_oe ? i_one_out : 1'b1;
	assign o_line_two = i_two_oe ? i_two_out : 1'b1;
endmodule // mic_host_model

// ==== bench/mic_monitor.sv ====
////////////////////////////////
// Purpose: port checks of the interrupt control block
// Assumes: host writes mirrored from the register port
// Notes:   pin checks wait one quiet cycle after a config write
////////////////////////////////
`timescale 1ns/1ns
module mic_monitor
	import mic_pkg::*;
#(
	parameter int TICK_CYCLES   = TICK_CYCLES_DEF,
	parameter int STABLE_CYCLES = STABLE_CYCLES_DEF
) (
	// clock, reset, register port
	input wire logic        i_clock,
	input wire logic        i_nrst,
	input wire logic [7:0]  i_reg_addr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        i_reg_wr,
	input wire logic        i_reg_rd,
	input wire logic [7:0]  o_reg_rdata,
	// detectors and pins
	input wire mic_events_s i_events,
	input wire logic        i_orient_updown,
	input wire logic [2:0]  i_orient_value,
	input wire logic [5:0]  i_tilt_angle,
	input wire logic [15:0] i_accel_peak,
	input wire logic [15:0] i_slope_peak,
	input wire mic_orient_e o_orient_mode,
	input wire logic        o_int_pin_one_out,
	input wire logic        o_int_pin_one_oe,
	input wire logic        o_int_pin_two_out,
	input wire logic        o_int_pin_two_oe
);
	logic [7:0] cfg_q;
	logic [4:0] en_q;
	// mirror of host writes
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			cfg_q <= REG_RESET;
			en_q  <= 5'h00;
		end else if (i_reg_wr && i_reg_addr == ADDR_PIN_CFG) begin
			cfg_q <= i_reg_wdata;
		end else if (i_reg_wr && i_reg_addr == ADDR_EN_HIGH) begin
			en_q  <= i_reg_wdata[4:0];
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	a_enable_readback: assert property (i_reg_rd && i_reg_addr == ADDR_EN_HIGH |=> o_reg_rdata == {3'h0, en_q})
		else $error("enable readback wrong");
	a_config_readback: assert property (i_reg_rd && i_reg_addr == ADDR_PIN_CFG |=> o_reg_rdata == cfg_q)
		else $error("pin config readback wrong");
	a_one_undriven: assert property (cfg_q[1:0] == DRV_NONE && $stable(cfg_q) |=> !o_int_pin_one_oe)
		else $error("pin one driven in no-output mode");
	a_two_open_drain: assert property (cfg_q[3:2] == DRV_OPEN && $stable(cfg_q) |=> !o_int_pin_two_out)
		else $error("pin two drives high in open drain");
	a_one_push_pull: assert property (cfg_q[0] && $stable(cfg_q) |=> o_int_pin_one_oe)
		else $error("pin one not driven in push-pull");
	a_polarity_pair: assert property (cfg_q[0] && cfg_q[2] && !cfg_q[6] && $stable(cfg_q)
		|=> (o_int_pin_one_out ^ cfg_q[5]) == (o_int_pin_two_out ^ cfg_q[7])) else $error("pin polarity mismatch");
	a_event_to_pin: assert property (i_events.high[0] && en_q[0] && cfg_q[3:2] == 2'h1 && !i_reg_wr
		##1 !i_reg_wr |=> o_int_pin_two_out == !cfg_q[7]) else $error("enabled event did not assert pin");
	a_status_clear: assert property (i_reg_rd && i_reg_addr == ADDR_STATUS_HIGH && i_events == '0 && cfg_q[3:2] == 2'h1
		##1 (i_events == '0 && !i_reg_wr) |=> o_int_pin_two_out == cfg_q[7]) else $error("status read did not clear pin");
	a_orient_mode: assert property (i_reg_wr && i_reg_addr == ADDR_BLOCK_MODE && i_reg_wdata[1:0] == MODE_HIGH
		|-> ##[1:2] o_orient_mode == ORIENT_HIGH_ASYM) else $error("orientation mode not high asymmetrical");
	c_pulse_end: cover property (cfg_q[6] && $fell(o_int_pin_one_out));
	c_open_drain: cover property (cfg_q[1:0] == DRV_OPEN && o_int_pin_one_oe);
	c_status_read: cover property (i_reg_rd && i_reg_addr == ADDR_STATUS_LOW);
endmodule // mic_monitor
bind mic_motion_interrupt_control mic_monitor #(.TICK_CYCLES(TICK_CYCLES), .STABLE_CYCLES(STABLE_CYCLES)) mic_monitor_inst (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_events(i_events), .i_orient_updown(i_orient_updown),
	.i_orient_value(i_orient_value), .i_tilt_angle(i_tilt_angle), .i_accel_peak(i_accel_peak),
	.i_slope_peak(i_slope_peak), .o_orient_mode(o_orient_mode), .o_int_pin_one_out(o_int_pin_one_out),
	.o_int_pin_one_oe(o_int_pin_one_oe), .o_int_pin_two_out(o_int_pin_two_out), .o_int_pin_two_oe(o_int_pin_two_oe));

// ==== bench/mic_motion_interrupt_control_bench.sv ====
////////////////////////////////
// Purpose: self-checking bench of the interrupt control block
// Assumes: short tick and stability counts
// Notes:   inputs move on the falling clock edge
////////////////////////////////
`timescale 1ns/1ns
module mic_motion_interrupt_control_bench
	import mic_pkg::*;
;
	typedef struct packed {
		logic [7:0] en_low, en_high;
		mic_events_s ev;
		logic [7:0] exp_low, exp_high;
	} mic_row_s;
	typedef struct packed {
		logic [7:0]  blk, ang;
		logic [15:0] acc, slope;
		logic        ud, keep;
	} mic_orow_s;
	logic i_clock = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_orient_updown = 1'b0;
	logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
	logic [5:0] i_tilt_angle = 6'h00;
	logic [2:0] i_orient_value = 3'h2;
	logic [15:0] i_accel_peak = 16'h0000, i_slope_peak = 16'h0000;
	mic_events_s i_events = '0;
	mic_orient_e o_orient_mode;
	logic o_int_pin_one_out, o_int_pin_one_oe, o_int_pin_two_out, o_int_pin_two_oe, line_one, line_two;
	int fails = 0, check_count = 0;
	mic_row_s rows [5] = '{{8'hFF, 8'h00, 13'h1FFF, 8'hFF, 8'h00}, {8'h00, 8'h1F, 13'h1FFF, 8'h00, 8'h1F},
		{8'hAA, 8'h15, 13'h1FFF, 8'hAA, 8'h15}, {8'h55, 8'h0A, 13'h1FFF, 8'h55, 8'h0A}, {8'h00, 8'h00, 13'h1FFF, 16'h0000}};
	mic_orow_s orows [8] = '{{16'h0501, 32'h02000000, 2'b00}, {16'h0601, 32'h00500030, 2'b01},
		{16'h0B01, 32'h00500030, 2'b00}, {16'h0C01, 32'h00500030, 2'b01}, {16'h0C01, 32'h00500050, 2'b00},
		{16'h0041, 32'h02000000, 2'b10}, {16'h0001, 32'h02000000, 2'b11}, {16'h043F, 32'h00500000, 2'b00}};
	logic [7:0] cfgs [7] = '{8'h00, 8'h05, 8'hA5, 8'h0F, 8'h0A, 8'h8A, 8'h2E};
	// device and host
	mic_motion_interrupt_control #(.TICK_CYCLES(4), .STABLE_CYCLES(20)) mic_motion_interrupt_control_inst (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_events(i_events), .i_orient_updown(i_orient_updown),
		.i_orient_value(i_orient_value), .i_tilt_angle(i_tilt_angle), .i_accel_peak(i_accel_peak),
		.i_slope_peak(i_slope_peak),
		.o_orient_mode(o_orient_mode), .o_int_pin_one_out(o_int_pin_one_out), .o_int_pin_one_oe(o_int_pin_one_oe),
		.o_int_pin_two_out(o_int_pin_two_out), .o_int_pin_two_oe(o_int_pin_two_oe));
	mic_host_model mic_host_model_inst (.i_one_out(o_int_pin_one_out), .i_one_oe(o_int_pin_one_oe),
		.i_two_out(o_int_pin_two_out), .i_two_oe(o_int_pin_two_oe), .o_line_one(line_one), .o_line_two(line_two));
	// 25 MHz clock
	always #20 i_clock = ~i_clock;
	// compare, bus cycles, event pulse, verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		check_count++;
		if (got !== e) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clock);
		{i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
		@(negedge i_clock);
		i_reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_clock);
		{i_reg_addr, i_reg_rd} = {a, 1'b1};
		@(negedge i_clock);
		i_reg_rd = 1'b0;
		chk(o_reg_rdata, e);
	endtask
	task automatic fire(input mic_events_s ev);
		@(negedge i_clock);
		i_events = ev;
		@(negedge i_clock);
		i_events = '0;
		@(negedge i_clock);
	endtask
	function automatic logic [7:0] pin_exp(input logic [1:0] drv, input logic pol, input logic act);
		if (drv == DRV_NONE) return 8'h00;
		if (drv == DRV_OPEN) return {7'h00, !(act ^ pol)};
		return {6'h00, act ^ pol, 1'b1};
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// watchdog
	initial begin
		#200_000;
		fails++;
		give_verdict;
	end
	// main sequence
	initial begin
		repeat (12) @(negedge i_clock);
		i_nrst = 1'b1;
		wr(ADDR_PIN_CFG, 8'h05);
		wr(ADDR_ANGLE_CFG, 8'h01);
		foreach (rows[i]) begin
			wr(ADDR_EN_LOW, rows[i].en_low);
			wr(ADDR_EN_HIGH, rows[i].en_high);
			fire(rows[i].ev);
			chk({7'h00, line_two}, {7'h00, |{rows[i].exp_low, rows[i].exp_high}});
			rd(ADDR_STATUS_LOW, rows[i].exp_low);
			fire(rows[i].ev);
			rd(ADDR_STATUS_HIGH, rows[i].exp_high);
			@(negedge i_clock);
			chk({7'h00, line_two}, 8'h00);
		end
		wr(ADDR_EN_HIGH, 8'h01); // free fall only, for the pin and pulse cases
		for (int p = 1; p >= 0; p--) begin
			if (p == 1) fire(13'h0001);
			foreach (cfgs[k]) begin
				wr(ADDR_PIN_CFG, cfgs[k]);
				@(negedge i_clock);
				chk({6'h00, o_int_pin_one_out, o_int_pin_one_oe}, pin_exp(cfgs[k][1:0], cfgs[k][5], p[0]));
				chk({6'h00, o_int_pin_two_out, o_int_pin_two_oe}, pin_exp(cfgs[k][3:2], cfgs[k][7], p[0]));
			end
			rd(ADDR_STATUS_HIGH, {7'h00, p[0]});
		end
		for (int m = 0; m < 2; m++) begin
			wr(ADDR_PIN_CFG, m ? 8'h05 : 8'h15);
			fire(13'h0001);
			rd(ADDR_PULSE_LEN, 8'h00);
			@(negedge i_clock);
			chk({7'h00, line_two}, 8'(m));
		end
		rd(ADDR_STATUS_HIGH, 8'h01);
		wr(ADDR_PULSE_LEN, 8'h03);
		wr(ADDR_PIN_CFG, 8'h45);
		fire(13'h0001);
		chk({6'h00, line_one, line_two}, 8'h03);
		repeat (16) @(negedge i_clock);
		chk({6'h00, line_one, line_two}, 8'h01);
		rd(ADDR_STATUS_HIGH, 8'h01);
		wr(ADDR_EN_LOW, 8'h01);
		wr(ADDR_LIMIT_HIGH, 8'h01);
		i_tilt_angle = 6'h05;
		foreach (orows[j]) begin
			{i_accel_peak, i_slope_peak, i_orient_updown} = {orows[j].acc, orows[j].slope, orows[j].ud};
			wr(ADDR_BLOCK_MODE, orows[j].blk);
			wr(ADDR_ANGLE_CFG, orows[j].ang);
			fire(13'h0020);
			rd(ADDR_STATUS_LOW, {7'h00, orows[j].keep});
			chk({6'h00, o_orient_mode}, {6'h00, (orows[j].blk[1:0] == 2'h3) ? 2'h0 : orows[j].blk[1:0]});
		end
		// a freshly moved orientation is held back until it settles; flat needs tilt under theta
		wr(ADDR_EN_LOW, 8'h03);
		wr(ADDR_BLOCK_MODE, 8'h0C);
		wr(ADDR_ANGLE_CFG, 8'h01);
		for (int s = 0; s < 2; s++) begin
			i_orient_value = s ? 3'h4 : 3'h3;
			repeat (s * 24) @(negedge i_clock);
			fire(13'h0060);
			rd(ADDR_STATUS_LOW, s ? 8'h01 : 8'h00);
		end
		i_nrst = 1'b0;
		repeat (2) @(negedge i_clock);
		i_nrst = 1'b1;
		for (int a = 8'h40; a <= 8'h47; a++) rd(a[7:0], REG_RESET);
		chk({6'h00, o_int_pin_one_oe, o_int_pin_two_oe}, 8'h00);
		wr(ADDR_EN_HIGH, 8'hFF);
		rd(ADDR_EN_HIGH, 8'h1F);
		wr(ADDR_BLOCK_MODE, 8'hFF);
		rd(ADDR_BLOCK_MODE, 8'h0F);
		rd(8'h30, 8'h00);
		give_verdict;
	end
endmodule // mic_motion_interrupt_control_bench
